// ### hw/msd_pkg.sv
// Constants, register map and carriers shared by the motion sensor core.
// Assumes a 125 MHz core clock and a byte-addressed Avalon-MM host.
// Summary of operation
// - Gyro range selectable among four settings.
// - Each rotation axis sample is 16 bits.
// - Sample rate from 8000 down to 3.9 Hz.
// - Accel range selectable among 2, 4, 8, 16g.
// - Core is always a target, never initiates.
// - Address LSB follows the address-select pin.
// - Self-test enabled separately per sensor axis.
// - Clock source: relaxation oscillator or auto-select.
// - Latest results held in read-only registers.
// - Buffer holds up to 1008 bytes.
// - Buffer config selects which items are stored.
// - Byte counter tracks valid buffered bytes.
// - Data port pops successive bytes per read.
// - Buffer readable in accel low-power mode.
// - Watermark reach raises data-ready class interrupt.
// - Interrupt config sets drive, latching, clearing, second-pin routing.
// - Events: clock lock, new data, motion, overflow.
// - Pending sources readable in status register.
// - Temperature available in buffer and results.
// - Eight power modes, sleep through duty-cycled six-axis.
// - Second pin takes motion, overflow, frame-sync events.
// - Motion when filtered sample exceeds axis threshold.
package msd_pkg;
    localparam int CLK_MHZ = 125;
    localparam int INT_PULSE_US = 50;
    localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
    localparam int FIFO_DEPTH = 1008;
    localparam int SAMPLE_BITS = 112;
    localparam int PUSH_BYTES = 15;
    localparam logic [3:0] RATE_SEL_MAX = 4'hB;
    localparam logic [5:0] I2C_ADDR_BASE = 6'h34;
    localparam logic [6:0] OFS_RANGE = 7'h00;
    localparam logic [6:0] OFS_RATE = 7'h04;
    localparam logic [6:0] OFS_STEST = 7'h08;
    localparam logic [6:0] OFS_PMODE = 7'h0C;
    localparam logic [6:0] OFS_FCFG = 7'h10;
    localparam logic [6:0] OFS_FWM = 7'h14;
    localparam logic [6:0] OFS_FCNT = 7'h18;
    localparam logic [6:0] OFS_FDATA = 7'h1C;
    localparam logic [6:0] OFS_ICFG = 7'h20;
    localparam logic [6:0] OFS_IEN = 7'h24;
    localparam logic [6:0] OFS_ISTAT = 7'h28;
    localparam logic [6:0] OFS_WOM = 7'h2C;
    localparam logic [6:0] OFS_GXY = 7'h30;
    localparam logic [6:0] OFS_GZAX = 7'h34;
    localparam logic [6:0] OFS_AYZ = 7'h38;
    localparam logic [6:0] OFS_TEMP = 7'h3C;
    localparam logic [4:0] RST_RANGE = 5'h10;
    localparam logic [4:0] RST_ICFG = 5'h04;
    localparam logic [5:0] SECOND_INTERRUPT_OUTPUT_MAP = 6'h1C;
    localparam int ST_LOCK = 0;
    localparam int ST_DRDY = 1;
    localparam int ST_WOM = 2;
    localparam int ST_OVF = 3;
    localparam int ST_FRAME_SYNC_INPUT = 4;
    localparam int ST_WM = 5;

    typedef struct packed {
        logic [15:0] gx, gy, gz, ax, ay, az, temp;
    } msd_sample_type;

    typedef struct packed {
        logic gyro_drive, gyro_on, gyro_duty, accel_on, accel_duty;
    } msd_power_type;

    typedef struct packed {
        logic [1:0] gyro_fs;
        logic [1:0] accel_fs;
        logic [5:0] selftest;
        logic clk_auto;
        msd_power_type power;
    } msd_afe_ctrl_type;

    typedef struct packed {
        logic frame_sync_input, temp, accel, gyro;
    } msd_fifo_cfg_type;

    typedef struct packed {
        logic second_interrupt_output_en, clr_any, latch, od2, od1;
    } msd_int_cfg_type;

    typedef struct packed {
        logic and_mode;
        logic [2:0] en;
        logic [7:0] thr_z, thr_y, thr_x;
    } msd_wom_type;
endpackage

// ### hw/msd_sync.sv
// Two-flop synchroniser bank for pins from outside the core clock.
// Assumes every bit is an independent level; no bus coherence is kept.
`timescale 1ns/1ps
module msd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule

// ### hw/msd_fifo_mem.sv
// Byte memory behind the sample buffer, one write and one read port.
// Read data are registered and follow the read address one clock late.
`timescale 1ns/1ps
module msd_fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 1008,
    parameter int AW = 10
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic [AW-1:0] i_rd_addr,
    output logic [WIDTH-1:0] o_rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rd_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rd_reg <= '0;
        end else begin
            rd_reg <= mem[i_rd_addr];
        end
    end

    assign o_rd_data = rd_reg;
endmodule

// ### hw/msd_core.sv
// Motion sensor data core: registers, sample intake, buffer, interrupts.
// Assumes converters deliver frames on a slow serial link (clock, frame,
// data) and a host that reaches the registers over Avalon-MM.
`timescale 1ns/1ps
module msd_core #(
    parameter int DEPTH = msd_pkg::FIFO_DEPTH,
    parameter int PULSE_CYC = msd_pkg::INT_PULSE_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [6:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_link_clk,
    input wire logic i_link_frame,
    input wire logic i_link_data,
    input wire logic i_frame_sync_input,
    input wire logic i_address_select_pin,
    input wire logic i_clk_locked,
    output msd_pkg::msd_afe_ctrl_type o_afe_ctrl,
    output logic [6:0] o_i2c_address,
    output logic o_first_interrupt_output,
    output logic o_first_interrupt_output_oe,
    output logic o_second_interrupt_output,
    output logic o_second_interrupt_output_oe
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = $clog2(PULSE_CYC + 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_PUSH = 2'b10
    } msd_push_state_type;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    function automatic logic over_thr(input logic [15:0] now,
                                      input logic [15:0] old,
                                      input logic [7:0] thr);
        logic [15:0] d;
        d = 16'(now - old);
        if (d[15]) begin
            d = 16'(~d + 16'h0001);
        end
        over_thr = d > {4'h0, thr, 4'h0};
    endfunction

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    function automatic logic hit(input logic [6:0] a, input logic [6:0] o);
        hit = a[6:2] == o[6:2];
    endfunction

    function automatic msd_pkg::msd_power_type pwr(input logic [2:0] m);
        case (m)
            3'h0: pwr = 5'h00;
            3'h1: pwr = 5'h10;
            3'h2: pwr = 5'h01;
            3'h3: pwr = 5'h02;
            3'h4: pwr = 5'h14;
            3'h5: pwr = 5'h18;
            3'h6: pwr = 5'h1A;
            default: pwr = 5'h16;
        endcase
    endfunction

    // Pin synchronisers; every link signal is sampled on the core clock.
    logic [5:0] s_pins;
    msd_sync #(.WIDTH(6)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async({i_clk_locked, i_address_select_pin, i_frame_sync_input,
                  i_link_data, i_link_frame, i_link_clk}),
        .o_sync(s_pins)
    );
    wire s_lclk = s_pins[0];
    wire s_frame = s_pins[1];
    wire s_data = s_pins[2];
    wire s_frame_sync_input = s_pins[3];
    wire s_addr = s_pins[4];
    wire s_lock = s_pins[5];

    logic [4:0] range_reg;
    logic [3:0] rate_reg;
    logic [5:0] stest_reg;
    logic [2:0] pmode_reg;
    msd_pkg::msd_fifo_cfg_type fcfg_reg;
    logic [CW-1:0] wm_reg;
    msd_pkg::msd_int_cfg_type icfg_reg;
    logic [5:0] ien_reg;
    msd_pkg::msd_wom_type wom_reg;
    logic [5:0] status_reg;
    logic [5:0] status_next;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rd_mux;

    // Every access takes exactly one wait cycle; the core is only ever
    // a target and never starts a transfer of its own.
    wire req = i_avs_read | i_avs_write;
    wire rd_first = i_avs_read & ~ack_reg;
    wire wr_commit = i_avs_write & ack_reg;
    wire [31:0] wd = i_avs_writedata;
    wire [3:0] be = i_avs_byteenable;
    wire [6:0] adr = i_avs_address;
    assign o_avs_waitrequest = req & ~ack_reg;
    assign o_avs_readdata = rdata_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (rd_first) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            range_reg <= msd_pkg::RST_RANGE;
            rate_reg <= '0;
            stest_reg <= '0;
            pmode_reg <= '0;
            fcfg_reg <= '0;
            wm_reg <= '0;
            icfg_reg <= msd_pkg::RST_ICFG;
            ien_reg <= '0;
            wom_reg <= '0;
        end else if (wr_commit) begin
            if (hit(adr, msd_pkg::OFS_RANGE)) begin
                range_reg <= 5'(merge(32'(range_reg), wd, be));
            end
            if (hit(adr, msd_pkg::OFS_RATE)) begin
                rate_reg <= 4'(merge(32'(rate_reg), wd, be));
            end
            if (hit(adr, msd_pkg::OFS_STEST)) begin
                stest_reg <= 6'(merge(32'(stest_reg), wd, be));
            end
            if (hit(adr, msd_pkg::OFS_PMODE)) begin
                pmode_reg <= 3'(merge(32'(pmode_reg), wd, be));
            end
            if (hit(adr, msd_pkg::OFS_FCFG)) begin
                fcfg_reg <= 4'(merge(32'(fcfg_reg), wd, be));
            end
            if (hit(adr, msd_pkg::OFS_FWM)) begin
                wm_reg <= CW'(merge(32'(wm_reg), wd, be));
            end
            if (hit(adr, msd_pkg::OFS_ICFG)) begin
                icfg_reg <= 5'(merge(32'(icfg_reg), wd, be));
            end
            if (hit(adr, msd_pkg::OFS_IEN)) begin
                ien_reg <= 6'(merge(32'(ien_reg), wd, be));
            end
            if (hit(adr, msd_pkg::OFS_WOM)) begin
                wom_reg <= 28'(merge(32'(wom_reg), wd, be));
            end
        end
    end

    msd_pkg::msd_power_type pw;
    assign pw = pwr(pmode_reg);
    wire gyro_data = pw.gyro_on | pw.gyro_duty;
    wire accel_data = pw.accel_on | pw.accel_duty;
    assign o_afe_ctrl = {range_reg[1:0], range_reg[3:2], stest_reg,
                         range_reg[4], pw};
    assign o_i2c_address = {msd_pkg::I2C_ADDR_BASE, s_addr};

    // Serial frame intake and rate division.
    logic lclk_prev_reg;
    logic frame_prev_reg;
    logic lock_prev_reg;
    logic frame_sync_input_prev_reg;
    logic fs_seen_reg;
    logic [msd_pkg::SAMPLE_BITS-1:0] shift_reg;
    logic [6:0] bits_reg;
    logic [10:0] div_reg;
    msd_pkg::msd_sample_type smp_reg;

    wire lclk_rise = s_lclk & ~lclk_prev_reg;
    wire frame_fall = ~s_frame & frame_prev_reg;
    wire frame_ok = frame_fall & (bits_reg == 7'(msd_pkg::SAMPLE_BITS));
    wire [3:0] sel = (rate_reg > msd_pkg::RATE_SEL_MAX) ?
                     msd_pkg::RATE_SEL_MAX : rate_reg;
    wire [10:0] div_lim = 11'((12'h001 << sel) - 12'h001);
    wire take = frame_ok & (div_reg == 11'h000) & (gyro_data | accel_data);
    wire frame_sync_input_rise = s_frame_sync_input & ~frame_sync_input_prev_reg;
    wire lock_rise = s_lock & ~lock_prev_reg;
    msd_pkg::msd_sample_type new_smp;
    assign new_smp = shift_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            lclk_prev_reg <= 1'b0;
            frame_prev_reg <= 1'b0;
            lock_prev_reg <= 1'b0;
            frame_sync_input_prev_reg <= 1'b0;
            shift_reg <= '0;
            bits_reg <= '0;
            div_reg <= '0;
        end else begin
            lclk_prev_reg <= s_lclk;
            frame_prev_reg <= s_frame;
            lock_prev_reg <= s_lock;
            frame_sync_input_prev_reg <= s_frame_sync_input;
            if (frame_fall) begin
                bits_reg <= '0;
            end else if (lclk_rise & s_frame) begin
                shift_reg <= {shift_reg[msd_pkg::SAMPLE_BITS-2:0], s_data};
                bits_reg <= 7'(bits_reg + 1'b1);
            end
            if (frame_ok) begin
                div_reg <= (div_reg >= div_lim) ? '0 : 11'(div_reg + 1'b1);
            end
        end
    end

    // Result registers keep the newest 16-bit words per axis.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            smp_reg <= '0;
            fs_seen_reg <= 1'b0;
        end else begin
            if (take & gyro_data) begin
                smp_reg.gx <= new_smp.gx;
                smp_reg.gy <= new_smp.gy;
                smp_reg.gz <= new_smp.gz;
            end
            if (take & accel_data) begin
                smp_reg.ax <= new_smp.ax;
                smp_reg.ay <= new_smp.ay;
                smp_reg.az <= new_smp.az;
            end
            if (take) begin
                smp_reg.temp <= new_smp.temp;
            end
            fs_seen_reg <= frame_sync_input_rise | (fs_seen_reg & ~take);
        end
    end

    // The high-pass term is the step from the previous stored sample.
    wire [2:0] wom_ov = {
        over_thr(new_smp.az, smp_reg.az, wom_reg.thr_z),
        over_thr(new_smp.ay, smp_reg.ay, wom_reg.thr_y),
        over_thr(new_smp.ax, smp_reg.ax, wom_reg.thr_x)};
    wire wom_any = |(wom_ov & wom_reg.en);
    wire wom_all = (&(wom_ov | ~wom_reg.en)) & (|wom_reg.en);
    wire wom_hit = take & accel_data &
                   (wom_reg.and_mode ? wom_all : wom_any);

    // Push sequencer walks one byte per clock through the sample.
    msd_push_state_type state_reg;
    msd_push_state_type state_next;
    logic [119:0] pbuf_reg;
    logic [14:0] pmask_reg;
    logic [3:0] pcnt_reg;
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] cnt_reg;
    logic [7:0] mem_dout;

    wire [14:0] mask_in = {{6{fcfg_reg.gyro & gyro_data}},
                           {6{fcfg_reg.accel & accel_data}},
                           {2{fcfg_reg.temp}}, fcfg_reg.frame_sync_input};
    wire pushing = state_reg == ST_PUSH;
    wire push_req = pushing & pmask_reg[14];
    wire full = cnt_reg == CW'(DEPTH);
    wire push_ok = push_req & ~full;
    wire ovf_hit = push_req & full;
    wire pop = rd_first & hit(adr, msd_pkg::OFS_FDATA) &
               (cnt_reg != '0);
    wire [CW-1:0] cnt_next = CW'(cnt_reg + push_ok - pop);
    wire wm_hit = (wm_reg != '0) & (cnt_next >= wm_reg) &
                  (cnt_reg < wm_reg);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    state_next = ST_PUSH;
                end
            end
            ST_PUSH: begin
                if (pcnt_reg == 4'(msd_pkg::PUSH_BYTES - 1)) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            pbuf_reg <= '0;
            pmask_reg <= '0;
            pcnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE) begin
                pcnt_reg <= '0;
                pbuf_reg <= {new_smp, 7'h00, fs_seen_reg};
                pmask_reg <= mask_in;
            end else begin
                pcnt_reg <= 4'(pcnt_reg + 1'b1);
                pbuf_reg <= {pbuf_reg[111:0], 8'h00};
                pmask_reg <= {pmask_reg[13:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            if (push_ok) begin
                wr_ptr_reg <= next_ptr(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= next_ptr(rd_ptr_reg);
            end
        end
    end

    msd_fifo_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_wr_en(push_ok),
        .i_wr_addr(wr_ptr_reg),
        .i_wr_data(pbuf_reg[119:112]),
        .i_rd_addr(rd_ptr_reg),
        .o_rd_data(mem_dout)
    );

    always_comb begin
        case (adr[6:2])
            msd_pkg::OFS_RANGE[6:2]: rd_mux = 32'(range_reg);
            msd_pkg::OFS_RATE[6:2]: rd_mux = 32'(rate_reg);
            msd_pkg::OFS_STEST[6:2]: rd_mux = 32'(stest_reg);
            msd_pkg::OFS_PMODE[6:2]: rd_mux = 32'(pmode_reg);
            msd_pkg::OFS_FCFG[6:2]: rd_mux = 32'(fcfg_reg);
            msd_pkg::OFS_FWM[6:2]: rd_mux = 32'(wm_reg);
            msd_pkg::OFS_FCNT[6:2]: rd_mux = 32'(cnt_reg);
            msd_pkg::OFS_FDATA[6:2]:
                rd_mux = (cnt_reg != '0) ? 32'(mem_dout) : 32'h0000_0000;
            msd_pkg::OFS_ICFG[6:2]: rd_mux = 32'(icfg_reg);
            msd_pkg::OFS_IEN[6:2]: rd_mux = 32'(ien_reg);
            msd_pkg::OFS_ISTAT[6:2]: rd_mux = 32'(status_reg);
            msd_pkg::OFS_WOM[6:2]: rd_mux = 32'(wom_reg);
            msd_pkg::OFS_GXY[6:2]: rd_mux = {smp_reg.gy, smp_reg.gx};
            msd_pkg::OFS_GZAX[6:2]: rd_mux = {smp_reg.ax, smp_reg.gz};
            msd_pkg::OFS_AYZ[6:2]: rd_mux = {smp_reg.az, smp_reg.ay};
            msd_pkg::OFS_TEMP[6:2]: rd_mux = 32'(smp_reg.temp);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Status flags are sticky; a new event wins over a clear in the same
    // cycle so that no event is lost between read and clear.
    logic [5:0] set_vec;
    always_comb begin
        set_vec = '0;
        set_vec[msd_pkg::ST_LOCK] = lock_rise;
        set_vec[msd_pkg::ST_DRDY] = take;
        set_vec[msd_pkg::ST_WOM] = wom_hit;
        set_vec[msd_pkg::ST_OVF] = ovf_hit;
        set_vec[msd_pkg::ST_FRAME_SYNC_INPUT] = frame_sync_input_rise;
        set_vec[msd_pkg::ST_WM] = wm_hit;
    end
    wire clr_stat = rd_first & (icfg_reg.clr_any |
                    hit(adr, msd_pkg::OFS_ISTAT));
    assign status_next = (status_reg & ~{6{clr_stat}}) | set_vec;

    // Pin routing and drive. Unlatched interrupts give a fixed pulse.
    wire [5:0] map2 = icfg_reg.second_interrupt_output_en ? msd_pkg::SECOND_INTERRUPT_OUTPUT_MAP : 6'h00;
    wire [5:0] map1 = ~map2;
    wire [5:0] pend = status_reg & ien_reg;
    wire [5:0] fire = set_vec & ien_reg;
    logic [PW-1:0] pulse_reg [2];
    logic [1:0] lvl_reg;
    wire [1:0] pend_pin = {|(pend & map2), |(pend & map1)};
    wire [1:0] fire_pin = {|(fire & map2), |(fire & map1)};

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            status_reg <= '0;
            lvl_reg <= '0;
            pulse_reg[0] <= '0;
            pulse_reg[1] <= '0;
        end else begin
            status_reg <= status_next;
            for (int i = 0; i < 2; i++) begin
                if (fire_pin[i]) begin
                    pulse_reg[i] <= PW'(PULSE_CYC);
                end else if (pulse_reg[i] != '0) begin
                    pulse_reg[i] <= PW'(pulse_reg[i] - 1'b1);
                end
                lvl_reg[i] <= icfg_reg.latch ? pend_pin[i] :
                              (fire_pin[i] | (pulse_reg[i] > PW'(1)));
            end
        end
    end

    // Open drain pulls low while asserted; push-pull drives high.
    assign o_first_interrupt_output = icfg_reg.od1 ? 1'b0 : lvl_reg[0];
    assign o_first_interrupt_output_oe = icfg_reg.od1 ? lvl_reg[0] : 1'b1;
    assign o_second_interrupt_output = icfg_reg.od2 ? 1'b0 : lvl_reg[1];
    assign o_second_interrupt_output_oe = icfg_reg.od2 ? lvl_reg[1] : 1'b1;
endmodule

// ### tb/msd_chk.sv
// Assertions on the bus handshake, address and pins of msd_core.
// Bound to msd_core; sees only its ports.
`timescale 1ns/1ps
module msd_chk (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic i_address_select_pin,
    input wire logic [6:0] o_i2c_address,
    input wire msd_pkg::msd_afe_ctrl_type o_afe_ctrl,
    input wire logic o_first_interrupt_output,
    input wire logic o_first_interrupt_output_oe,
    input wire logic o_second_interrupt_output,
    input wire logic o_second_interrupt_output_oe
);
    wire rq = i_avs_read | i_avs_write;
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    chk_first_wait: assert property (
        $rose(rq) |-> o_avs_waitrequest) else $error("no wait cycle");
    chk_one_wait: assert property (
        rq && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("stall");
    chk_wait_cause: assert property (
        o_avs_waitrequest |-> rq) else $error("wait without request");
    chk_answer_after: assert property (
        rq && !o_avs_waitrequest |-> $past(o_avs_waitrequest))
        else $error("answer too early");
    chk_addr_lsb: assert property (
        $stable(i_address_select_pin)[*4]
        |-> o_i2c_address == {6'h34, i_address_select_pin})
        else $error("address");
    chk_pin1_drive: assert property (
        !o_first_interrupt_output || o_first_interrupt_output_oe)
        else $error("pin1 drive");
    chk_pin2_drive: assert property (
        !o_second_interrupt_output || o_second_interrupt_output_oe)
        else $error("pin2 drive");
    chk_power_code: assert property (
        o_afe_ctrl.power inside {5'h00, 5'h10, 5'h01, 5'h02, 5'h14, 5'h18,
        5'h1A, 5'h16}) else $error("power code");
endmodule
bind msd_core msd_chk u_chk (.i_core_clk, .i_rst, .i_avs_read, .i_avs_write,
    .o_avs_waitrequest, .i_address_select_pin, .o_i2c_address, .o_afe_ctrl,
    .o_first_interrupt_output, .o_first_interrupt_output_oe,
    .o_second_interrupt_output, .o_second_interrupt_output_oe);

// ### tb/msd_link_model.sv
// Converter side of the sample link: 112 bits a frame, MSB first.
// Assumes the bench calls send once per frame.
`timescale 1ns/1ps
module msd_link_model (
    output logic o_clk,
    output logic o_frame,
    output logic o_data
);
    initial begin
        o_clk = 1'b0;
        o_frame = 1'b0;
        o_data = 1'b0;
    end
    // Seven 16-bit words; the clock stands still between frames.
    task automatic send(input logic [111:0] s);
        o_frame = 1'b1;
        for (int i = 111; i >= 0; i--) begin
            o_data = s[i];
            #80 o_clk = 1'b1;
            #80 o_clk = 1'b0;
        end
        // Released data flips so a stale bit cannot pass for a match.
        o_data = ~o_data;
        #80 o_frame = 1'b0;
    endtask
endmodule

// ### tb/testbench.sv
// Bench for msd_core: registers, link frames, buffer and interrupt pins.
// Assumes the link model and the bound checker.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, pin = 1'b0;
    logic lock = 1'b0;
    logic [6:0] ad = 7'h00;
    logic [31:0] wd = 32'h0, seed = 32'hEF11;
    logic [31:0] q, rdata;
    logic [119:0] smp;
    logic wq, p1, p2, lc, lf, ld;
    logic [6:0] i2c;
    msd_pkg::msd_afe_ctrl_type afe;
    int fail_count = 0, n_tests = 0, i, k;
    logic [4:0] pw [8] = '{5'h00, 5'h10, 5'h01, 5'h02, 5'h14, 5'h18, 5'h1A,
        5'h16};
    msd_link_model lnk (.o_clk(lc), .o_frame(lf), .o_data(ld));
    msd_core #(.DEPTH(24), .PULSE_CYC(8)) uut (.i_core_clk(clk), .i_rst(rst),
        .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wq), .i_link_clk(lc), .i_link_frame(lf),
        .i_link_data(ld), .i_frame_sync_input(pin),
        .i_address_select_pin(pin), .i_clk_locked(lock), .o_afe_ctrl(afe),
        .o_i2c_address(i2c), .o_first_interrupt_output(p1),
        .o_first_interrupt_output_oe(), .o_second_interrupt_output(p2),
        .o_second_interrupt_output_oe());
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [6:0] a, input int d);
        int n = 0;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        ad <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wq !== 1'b0) begin
            fail_count++;
            print_verdict();
        end
    endtask
    // Polls the byte count; a count that never arrives fails the compare.
    task automatic poll(input int e);
        for (int n = 0; n < 100; n++) begin
            bus(1'b0, 7'h18, 0);
            if (q === e) break;
        end
        chk("count", e, q);
    endtask
    initial forever #4 clk = ~clk;
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        lock <= 1'b1;
        bus(1'b0, 7'h00, 0);
        chk("range", 32'h10, q);
        bus(1'b0, 7'h20, 0);
        chk("intcfg", 32'h04, q);
        for (i = 0; i < 4; i++) begin
            seed = xs(seed);
            bus(1'b1, 7'h00, {seed[4], 2'(3 - i), 2'(i)});
            bus(1'b1, 7'h08, seed);
            @(negedge clk);
            chk("gyro_fs", i, afe.gyro_fs);
            chk("accel_fs", 3 - i, afe.accel_fs);
            chk("clk_auto", seed[4], afe.clk_auto);
            chk("selftest", seed[5:0], afe.selftest);
        end
        for (i = 0; i < 8; i++) begin
            bus(1'b1, 7'h0C, i);
            @(negedge clk);
            chk("power", pw[i], afe.power);
        end
        for (i = 0; i < 2; i++) begin
            @(posedge clk) pin <= i[0];
            repeat (6) @(posedge clk);
            chk("i2c", {6'h34, i[0]}, i2c);
        end
        $display("test controls done");
        bus(1'b1, 7'h04, 0);
        bus(1'b1, 7'h0C, 6);
        bus(1'b1, 7'h10, 15);
        bus(1'b1, 7'h14, 15);
        bus(1'b1, 7'h20, 32'h14);
        bus(1'b1, 7'h24, 32'h22);
        for (k = 0; k < 4; k++) begin
            seed = xs(seed);
            smp = {smp[87:0], seed};
        end
        smp[7:0] = 8'h01;
        lnk.send(smp[119:8]);
        poll(15);
        chk("pin1", 1, p1);
        bus(1'b0, 7'h28, 0);
        chk("status", 32'h33, q);
        for (k = 0; k < 4; k++) begin
            bus(1'b0, 7'(7'h30 + 4 * k), 0);
            chk("result", smp[119 - 32 * k -: 16], q[15:0]);
            if (k < 3) chk("result", smp[103 - 32 * k -: 16], q[31:16]);
        end
        chk("pin1", 0, p1);
        for (k = 0; k < 15; k++) begin
            bus(1'b0, 7'h1C, 0);
            chk("pop", smp[119 - 8 * k -: 8], q);
        end
        poll(0);
        $display("test buffer done");
        bus(1'b1, 7'h0C, 2);
        bus(1'b1, 7'h10, 2);
        bus(1'b1, 7'h24, 32'h08);
        for (i = 1; i < 6; i++) begin
            lnk.send(smp[119:8]);
            poll(i < 5 ? 6 * i : 24);
        end
        for (k = 0; k < 100 && p2 !== 1'b1; k++) @(posedge clk);
        chk("pin2", 1, p2);
        chk("pin1", 0, p1);
        bus(1'b0, 7'h28, 0);
        chk("overflow", 1, q[3]);
        $display("test overflow done");
        print_verdict();
    end
endmodule
